/* hw/dmapp_addr_gen.sv */
// dmapp_addr_gen: current item address from an inclusive end pointer
// assumes remain_i counts the items still to move after this one
`timescale 1ns/1ps
module dmapp_addr_gen
  import dmapp_pkg::*;
(
  // end pointer and step
  input wire logic [31:0] end_i,
  input wire logic [1:0] inc_i,
  input wire logic [9:0] remain_i,
  // resulting address
  output logic [31:0] addr_o
);

  // walk backward from the end pointer; a fixed address never moves
  always_comb begin
    if (inc_i == DMAPP_INC_NONE) begin
      addr_o = end_i; // RULE8
    end else begin
      addr_o = end_i - ({22'h000000, remain_i} << inc_i); // RULE7 RULE9
    end
  end

endmodule

/* hw/dmapp_channel.sv */
// dmapp_channel: one ping-pong receive channel of a dma controller
// assumes memory answers a read in the next cycle and never stalls
//
// Behaviour
// RULE1 - enabled requested channel fills buffer via primary
// RULE2 - primary exhausted: switch to alternate automatically
// RULE3 - finished structure written stopped, completion signalled
// RULE4 - mode field bits 2:0 value 3 is ping-pong
// RULE5 - primary at table offset, alternate +0x200
// RULE6 - structure words: source, destination, control
// RULE7 - addresses count backward from inclusive end pointers
// RULE8 - source increment 3 keeps source address fixed
// RULE9 - destination increment 0 steps one byte
// RULE10 - size fields zero select byte items
// RULE11 - arbitration field sets items per round
// RULE12 - count field holds items minus one
// RULE13 - burst moves up to round, single moves one
// RULE14 - burst-only bit ignores single requests
// RULE15 - cleared mask bit lets requests through
// RULE16 - priority set and clear choose high priority
// RULE17 - alternate-select clear restarts from primary
// RULE18 - enable-set bit enables the channel
// RULE19 - software treats stopped mode as buffer full
// RULE20 - software rewrites completed control words
// RULE21 - next-use-burst bit ignored in ping-pong
// RULE22 - software keeps increment no smaller than size
// RULE23 - alternate done also stops, signals, returns primary
`timescale 1ns/1ps
module dmapp_channel
  import dmapp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // peripheral requests and answers
  input wire logic req_single_i,
  input wire logic req_burst_i,
  output logic round_end_o,
  output logic done_o,
  output logic prio_high_o,
  // system memory master
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic [1:0] mem_size_o,
  input wire logic [31:0] mem_rdata_i
);
  // items allowed in one round before the channel lets go of the bus
  function automatic logic [10:0] round_quota(input logic burst,
                                               input logic [3:0] arb);
    round_quota = !burst ? 11'h001 :
      (arb >= DMAPP_ARB_MAX_LOG) ? DMAPP_ARB_CAP : 11'h001 << arb;
  endfunction
  // attribute state
  logic ena_q, burst_only_q, mask_q, alt_q, prio_q;
  logic [31:0] base_q, rdata_q;
  // engine state
  dmapp_state_t st_q;
  logic [31:0] src_end_q, dst_end_q, ctl_q;
  logic [9:0] remain_q;
  logic [10:0] moved_q;
  logic burst_q, last_q, mem_rd_q, mem_wr_q;
  logic [31:0] mem_addr_q, mem_wdata_q;
  logic [1:0] size_q;
  // decoded helpers
  logic wr_bit, stop_now, done_now, go, last_item, round_full;
  logic [31:0] struct_base, src_addr, dst_addr, ctl_next, rd_val;
  logic [9:0] remain_sel;
  // attribute set and clear strobes act on this channel's bit only
  assign wr_bit = reg_wdata_i[DMAPP_CHANNEL];
  // a structure found not rewritten stops the channel
  assign stop_now = (st_q == DMAPP_X_DEC) &&
    (ctl_q[DMAPP_MODE_LSB +: DMAPP_MODE_W] != DMAPP_MODE_PINGPONG); // RULE4
  assign done_now = (st_q == DMAPP_WB) && last_q;
  // burst requests always count, single ones only when allowed
  assign go = ena_q && !mask_q && (req_burst_i ||
    (req_single_i && !burst_only_q)); // RULE1 RULE14 RULE15
  // primary entry, or the alternate one a fixed distance above it
  assign struct_base = base_q + DMAPP_PRI_OFF +
    (alt_q ? DMAPP_ALT_OFF : 32'h0000_0000); // RULE5
  assign last_item = (remain_q == 10'h000);
  assign round_full = ((moved_q + 11'h001) >=
    round_quota(burst_q, ctl_q[DMAPP_ARB_LSB +: DMAPP_ARB_W])); // RULE11 RULE13
  // remaining count that belongs to the item about to be addressed
  always_comb begin
    if (st_q == DMAPP_X_DEC) begin
      remain_sel = ctl_q[DMAPP_SIZE_LSB +: DMAPP_SIZE_W]; // RULE12
    end else if (st_q == DMAPP_X_WR) begin
      remain_sel = remain_q - 10'h001;
    end else begin
      remain_sel = remain_q;
    end
  end
  // updated control word; the next-burst bit is carried, never obeyed
  always_comb begin
    ctl_next = ctl_q; // RULE21
    if (last_item) begin
      ctl_next[DMAPP_MODE_LSB +: DMAPP_MODE_W] = DMAPP_MODE_STOP; // RULE3
      ctl_next[DMAPP_SIZE_LSB +: DMAPP_SIZE_W] = 10'h000;
    end else begin
      ctl_next[DMAPP_SIZE_LSB +: DMAPP_SIZE_W] = remain_q - 10'h001;
    end
  end
  // current item addresses, both walked back from their end pointers
  dmapp_addr_gen u_src_addr (
    .end_i(src_end_q), .inc_i(ctl_q[DMAPP_SINC_LSB +: 2]),
    .remain_i(remain_sel), .addr_o(src_addr));
  dmapp_addr_gen u_dst_addr (
    .end_i(dst_end_q), .inc_i(ctl_q[DMAPP_DINC_LSB +: 2]),
    .remain_i(remain_sel), .addr_o(dst_addr));
  // enable: software set wins over a stop found in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ena_q <= DMAPP_RST_BIT;
    end else if (reg_wr_i && reg_addr_i == DMAPP_OFF_ENA_SET && wr_bit) begin
      ena_q <= 1'b1; // RULE18
    end else if (stop_now ||
                 (reg_wr_i && reg_addr_i == DMAPP_OFF_ENA_CLR && wr_bit)) begin
      ena_q <= 1'b0;
    end
  end
  // burst-only attribute
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      burst_only_q <= DMAPP_RST_BIT;
    end else if (reg_wr_i && wr_bit) begin
      if (reg_addr_i == DMAPP_OFF_BURST_SET) begin
        burst_only_q <= 1'b1;
      end else if (reg_addr_i == DMAPP_OFF_BURST_CLR) begin
        burst_only_q <= 1'b0; // RULE14
      end
    end
  end
  // request mask attribute
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_q <= DMAPP_RST_BIT;
    end else if (reg_wr_i && wr_bit) begin
      if (reg_addr_i == DMAPP_OFF_MASK_SET) begin
        mask_q <= 1'b1;
      end else if (reg_addr_i == DMAPP_OFF_MASK_CLR) begin
        mask_q <= 1'b0; // RULE15
      end
    end
  end
  // priority only leaves the block; the arbiter sits elsewhere
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prio_q <= DMAPP_RST_BIT;
    end else if (reg_wr_i && wr_bit) begin
      if (reg_addr_i == DMAPP_OFF_PRIO_SET) begin
        prio_q <= 1'b1; // RULE16
      end else if (reg_addr_i == DMAPP_OFF_PRIO_CLR) begin
        prio_q <= 1'b0; // RULE16
      end
    end
  end
  // structure select: the changeover beats a software write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alt_q <= DMAPP_RST_BIT;
    end else if (done_now) begin
      alt_q <= ~alt_q; // RULE2 RULE23
    end else if (reg_wr_i && wr_bit) begin
      if (reg_addr_i == DMAPP_OFF_ALT_SET) begin
        alt_q <= 1'b1;
      end else if (reg_addr_i == DMAPP_OFF_ALT_CLR) begin
        alt_q <= 1'b0; // RULE17
      end
    end
  end
  // control table base; low bits forced so entries stay aligned
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_q <= DMAPP_RST_WORD;
    end else if (reg_wr_i && reg_addr_i == DMAPP_OFF_CTLBASE) begin
      base_q <= reg_wdata_i & DMAPP_CTLBASE_MASK;
    end
  end
  // read decode; write-only and unmapped offsets read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (reg_addr_i == DMAPP_OFF_STATUS) begin
      rd_val[DMAPP_STAT_BUSY] = (st_q != DMAPP_IDLE);
      rd_val[DMAPP_STAT_ALT] = alt_q;
    end else if (reg_addr_i == DMAPP_OFF_CTLBASE) begin
      rd_val = base_q;
    end else if (reg_addr_i == DMAPP_OFF_BURST_SET) begin
      rd_val[DMAPP_CHANNEL] = burst_only_q;
    end else if (reg_addr_i == DMAPP_OFF_MASK_SET) begin
      rd_val[DMAPP_CHANNEL] = mask_q;
    end else if (reg_addr_i == DMAPP_OFF_ENA_SET) begin
      rd_val[DMAPP_CHANNEL] = ena_q;
    end else if (reg_addr_i == DMAPP_OFF_ALT_SET) begin
      rd_val[DMAPP_CHANNEL] = alt_q;
    end else if (reg_addr_i == DMAPP_OFF_PRIO_SET) begin
      rd_val[DMAPP_CHANNEL] = prio_q;
    end
  end
  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= DMAPP_RST_WORD;
    end else if (reg_rd_i) begin
      rdata_q <= rd_val;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  // transfer engine; the structure is refetched on every round so
  // software rewrites between rounds are always seen
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= DMAPP_IDLE;
      src_end_q <= DMAPP_RST_WORD;
      dst_end_q <= DMAPP_RST_WORD;
      ctl_q <= DMAPP_RST_WORD;
      remain_q <= 10'h000;
      moved_q <= 11'h000;
      burst_q <= 1'b0;
      last_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_addr_q <= DMAPP_RST_WORD;
      mem_wdata_q <= DMAPP_RST_WORD;
      size_q <= 2'h0;
    end else begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      case (st_q)
        DMAPP_IDLE: begin
          if (go) begin
            st_q <= DMAPP_F_SRC;
            burst_q <= req_burst_i; // RULE13
            mem_rd_q <= 1'b1;
            mem_addr_q <= struct_base + DMAPP_SRC_OFF; // RULE6
          end
        end
        DMAPP_F_SRC: begin
          st_q <= DMAPP_F_DST;
          mem_rd_q <= 1'b1;
          mem_addr_q <= struct_base + DMAPP_DST_OFF; // RULE6
        end
        DMAPP_F_DST: begin
          st_q <= DMAPP_F_CTL;
          src_end_q <= mem_rdata_i;
          mem_rd_q <= 1'b1;
          mem_addr_q <= struct_base + DMAPP_CTL_OFF; // RULE6
        end
        DMAPP_F_CTL: begin
          st_q <= DMAPP_F_CHK;
          dst_end_q <= mem_rdata_i;
        end
        DMAPP_F_CHK: begin
          st_q <= DMAPP_X_DEC;
          ctl_q <= mem_rdata_i;
        end
        DMAPP_X_DEC: begin
          moved_q <= 11'h000;
          remain_q <= remain_sel;
          size_q <= ctl_q[DMAPP_SSZ_LSB +: 2]; // RULE10
          if (stop_now) begin
            st_q <= DMAPP_IDLE; // RULE23
          end else begin
            st_q <= DMAPP_X_RD;
            mem_rd_q <= 1'b1;
            mem_addr_q <= src_addr; // RULE8
          end
        end
        DMAPP_X_RD: begin
          st_q <= DMAPP_X_CAP;
        end
        DMAPP_X_CAP: begin
          st_q <= DMAPP_X_WR;
          mem_wr_q <= 1'b1;
          mem_addr_q <= dst_addr; // RULE9
          mem_wdata_q <= mem_rdata_i;
        end
        DMAPP_X_WR: begin
          moved_q <= moved_q + 11'h001;
          if (last_item || round_full) begin
            st_q <= DMAPP_WB;
            last_q <= last_item;
            mem_wr_q <= 1'b1;
            mem_addr_q <= struct_base + DMAPP_CTL_OFF;
            mem_wdata_q <= ctl_next; // RULE3
          end else begin
            st_q <= DMAPP_X_RD;
            remain_q <= remain_sel;
            mem_rd_q <= 1'b1;
            mem_addr_q <= src_addr;
          end
        end
        DMAPP_WB: begin
          st_q <= DMAPP_IDLE;
          last_q <= 1'b0;
        end
        default: begin
          st_q <= DMAPP_IDLE;
        end
      endcase
    end
  end
  // outputs
  assign reg_rdata_o = rdata_q;
  assign mem_rd_o = mem_rd_q;
  assign mem_wr_o = mem_wr_q;
  assign mem_addr_o = mem_addr_q;
  assign mem_wdata_o = mem_wdata_q;
  assign mem_size_o = size_q;
  assign prio_high_o = prio_q;
  assign round_end_o = (st_q == DMAPP_WB);
  assign done_o = done_now; // RULE3
  // checks on the engine clock; labels and messages say what each guards
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_MASKED_IDLE: // RULE15
  assert property ((st_q == DMAPP_IDLE && mask_q) |=> st_q == DMAPP_IDLE)
    else $error("masked channel left idle");
  AST_BURST_ONLY: // RULE14
  assert property ((st_q == DMAPP_IDLE && burst_only_q && !req_burst_i)
    |=> st_q == DMAPP_IDLE)
    else $error("single request served in burst-only mode");
  AST_FETCH_SEQ: // RULE6
  assert property ((st_q == DMAPP_IDLE && go) |=> mem_rd_o ##1
    (mem_rd_o && mem_addr_o == $past(mem_addr_o) + 32'h4) ##1
    (mem_rd_o && mem_addr_o == $past(mem_addr_o, 2) + 32'h8))
    else $error("structure fetch order wrong");
  AST_STRUCT_ADDR: // RULE5
  assert property ((st_q == DMAPP_F_SRC) |-> mem_addr_o ==
    base_q + DMAPP_PRI_OFF + (alt_q ? DMAPP_ALT_OFF : 32'h0))
    else $error("structure base address wrong");
  AST_STOP_WB: // RULE3
  assert property (done_o |-> (mem_wr_o && mem_wdata_o[2:0] == 3'h0 &&
    mem_addr_o[3:0] == 4'h8))
    else $error("completion without stopped write-back");
  AST_CHANGEOVER: // RULE2
  assert property (done_o |=> alt_q != $past(alt_q))
    else $error("no changeover after completion");
  AST_SINGLE_ONE: // RULE13
  assert property ((st_q == DMAPP_X_WR && !burst_q) |=> st_q == DMAPP_WB)
    else $error("single request moved more than one item");
  AST_SRC_FIXED: // RULE8
  assert property ((st_q == DMAPP_X_RD &&
    ctl_q[DMAPP_SINC_LSB +: 2] == DMAPP_INC_NONE)
    |-> mem_addr_o == src_end_q)
    else $error("fixed source address moved");
  AST_DST_END: // RULE7
  assert property ((st_q == DMAPP_X_WR && remain_q == 10'h000) |->
    mem_addr_o == dst_end_q)
    else $error("last item not at destination end");
  AST_STOP_DISABLE: // RULE4
  assert property ((stop_now && !reg_wr_i) |=> (!ena_q && st_q == DMAPP_IDLE))
    else $error("channel not stopped on non ping-pong structure");
endmodule

/* hw/dmapp_pkg.sv */
// dmapp_pkg: constants shared by the ping-pong receive channel files
// assumes a 32-bit system bus and a control table aligned to 1 KiB
package dmapp_pkg;

  // channel served by this instance; its bit in every attribute register
  localparam int unsigned DMAPP_CHANNEL = 8;

  // attribute register offsets on the register port (byte addresses)
  localparam logic [11:0] DMAPP_OFF_STATUS = 12'h000;
  localparam logic [11:0] DMAPP_OFF_CTLBASE = 12'h008;
  localparam logic [11:0] DMAPP_OFF_BURST_SET = 12'h018;
  localparam logic [11:0] DMAPP_OFF_BURST_CLR = 12'h01c;
  localparam logic [11:0] DMAPP_OFF_MASK_SET = 12'h020;
  localparam logic [11:0] DMAPP_OFF_MASK_CLR = 12'h024;
  localparam logic [11:0] DMAPP_OFF_ENA_SET = 12'h028;
  localparam logic [11:0] DMAPP_OFF_ENA_CLR = 12'h02c;
  localparam logic [11:0] DMAPP_OFF_ALT_SET = 12'h030;
  localparam logic [11:0] DMAPP_OFF_ALT_CLR = 12'h034;
  localparam logic [11:0] DMAPP_OFF_PRIO_SET = 12'h038;
  localparam logic [11:0] DMAPP_OFF_PRIO_CLR = 12'h03c;

  // status register bit positions
  localparam int unsigned DMAPP_STAT_BUSY = 0;
  localparam int unsigned DMAPP_STAT_ALT = 1;

  // control table layout
  localparam logic [31:0] DMAPP_CTLBASE_MASK = 32'hffff_fc00;
  localparam logic [31:0] DMAPP_PRI_OFF = 32'h0000_0080;
  localparam logic [31:0] DMAPP_ALT_OFF = 32'h0000_0200;
  localparam logic [31:0] DMAPP_SRC_OFF = 32'h0000_0000;
  localparam logic [31:0] DMAPP_DST_OFF = 32'h0000_0004;
  localparam logic [31:0] DMAPP_CTL_OFF = 32'h0000_0008;

  // control word fields
  localparam int unsigned DMAPP_MODE_LSB = 0;
  localparam int unsigned DMAPP_MODE_W = 3;
  localparam int unsigned DMAPP_NXTB_BIT = 3;
  localparam int unsigned DMAPP_SIZE_LSB = 4;
  localparam int unsigned DMAPP_SIZE_W = 10;
  localparam int unsigned DMAPP_ARB_LSB = 14;
  localparam int unsigned DMAPP_ARB_W = 4;
  localparam int unsigned DMAPP_SSZ_LSB = 24;
  localparam int unsigned DMAPP_SINC_LSB = 26;
  localparam int unsigned DMAPP_DSZ_LSB = 28;
  localparam int unsigned DMAPP_DINC_LSB = 30;

  // field encodings
  localparam logic [2:0] DMAPP_MODE_STOP = 3'h0;
  localparam logic [2:0] DMAPP_MODE_PINGPONG = 3'h3;
  localparam logic [1:0] DMAPP_INC_NONE = 2'h3;
  localparam logic [3:0] DMAPP_ARB_MAX_LOG = 4'ha;
  localparam logic [10:0] DMAPP_ARB_CAP = 11'h400;

  // values after reset
  localparam logic DMAPP_RST_BIT = 1'b0;
  localparam logic [31:0] DMAPP_RST_WORD = 32'h0000_0000;

  // engine states, gray coded along the transfer path
  typedef enum logic [3:0] {
    DMAPP_IDLE = 4'h0,
    DMAPP_F_SRC = 4'h1,
    DMAPP_F_DST = 4'h3,
    DMAPP_F_CTL = 4'h2,
    DMAPP_F_CHK = 4'h6,
    DMAPP_X_DEC = 4'h7,
    DMAPP_X_RD = 4'h5,
    DMAPP_X_CAP = 4'h4,
    DMAPP_X_WR = 4'hc,
    DMAPP_WB = 4'hd
  } dmapp_state_t;

endpackage

/* tb/dmapp_channel_tb.sv */
// dmapp_channel_tb: ping-pong receive of two 64-byte buffers
// assumes the peripheral model also serves the control table memory
`timescale 1ns/1ps
module dmapp_channel_tb;
  import dmapp_pkg::*;
  localparam logic [31:0] BASE = 32'h0000_0400;
  localparam logic [31:0] DREG = 32'h4000_c000;
  localparam logic [31:0] BUF_A = 32'h2000_0000;
  localparam logic [31:0] BUF_B = 32'h2000_0100;
  // byte step, fixed source, byte items, 8 a round, 64 items, ping-pong
  localparam logic [31:0] PP_WORD = 32'h0c00_c3f3;
  logic clk, rst, reg_wr, reg_rd, req_single, req_burst, round_end, done;
  logic prio_high, mem_rd, mem_wr, fill;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, w;
  logic [1:0] mem_size;
  logic [7:0] fill_n;
  logic [11:0] offs [9];
  int bad_count, checks, rounds, dones;

  dmapp_channel dut_u (.clk_i(clk), .rst_i(rst), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .req_single_i(req_single),
    .req_burst_i(req_burst), .round_end_o(round_end), .done_o(done),
    .prio_high_o(prio_high), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr),
    .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_size_o(mem_size),
    .mem_rdata_i(mem_rdata));
  dmapp_periph_model partner_u (.clk_i(clk), .rst_i(rst), .fill_i(fill),
    .fill_n_i(fill_n), .req_single_o(req_single), .req_burst_o(req_burst),
    .mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .mem_addr_i(mem_addr),
    .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata));

  always #50 clk = ~clk;

  task automatic close_out();
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // bus cycles: one-cycle strobes launched just after a rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk($sformatf("reg %h", a), reg_rdata, exp);
  endtask

  task automatic put(input logic [7:0] n);
    @(posedge clk);
    fill <= 1'b1;
    fill_n <= n;
    @(posedge clk);
    fill <= 1'b0;
  endtask

  // bounded wait for the end of one transfer round
  task automatic wait_round();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (round_end !== 1'b1 && n < 200);
    if (n >= 200) chk("round_wait", 32'h0, 32'h1);
  endtask

  // counts events; source must stay on the data register, items bytes
  always @(negedge clk) begin
    if (round_end === 1'b1) rounds++;
    if (done === 1'b1) dones++;
    if (mem_rd && mem_addr[31:12] != 20'h0)
      chk("src", mem_addr, DREG);
    if (mem_wr && mem_addr[31:28] == 4'h2)
      chk("size", {30'h0, mem_size}, 32'h0);
  end

  initial begin
    #3_000_000;
    bad_count++;
    close_out();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fill = 1'b0;
    fill_n = 8'h00;
    bad_count = 0;
    checks = 0;
    rounds = 0;
    dones = 0;
    offs = '{DMAPP_OFF_STATUS, DMAPP_OFF_CTLBASE, DMAPP_OFF_BURST_SET,
      DMAPP_OFF_BURST_CLR, DMAPP_OFF_MASK_SET, DMAPP_OFF_ENA_SET,
      DMAPP_OFF_ALT_SET, DMAPP_OFF_PRIO_SET, 12'h100};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(offs[i], 32'h0);
    // both structures start alike; the alternate also sets next-burst
    for (int s = 0; s < 2; s++) begin
      w = BASE + 32'h80 + 32'h200 * s;
      partner_u.mem[w] = DREG;
      partner_u.mem[w + 32'h4] = (s ? BUF_B : BUF_A) + 32'h3f;
      partner_u.mem[w + 32'h8] = PP_WORD | (s ? 32'h8 : 32'h0);
    end
    wr(DMAPP_OFF_CTLBASE, BASE);
    rd(DMAPP_OFF_CTLBASE, BASE);
    wr(DMAPP_OFF_PRIO_SET, 32'h100);
    @(negedge clk);
    chk("prio", {31'h0, prio_high}, 32'h1);
    wr(DMAPP_OFF_PRIO_CLR, 32'h100);
    @(negedge clk);
    chk("prio", {31'h0, prio_high}, 32'h0);
    wr(DMAPP_OFF_ALT_SET, 32'h100);
    rd(DMAPP_OFF_STATUS, 32'h2);
    wr(DMAPP_OFF_ALT_CLR, 32'h100);
    rd(DMAPP_OFF_STATUS, 32'h0);
    wr(DMAPP_OFF_BURST_CLR, 32'h100);
    wr(DMAPP_OFF_MASK_SET, 32'h100);
    wr(DMAPP_OFF_ENA_SET, 32'h100);
    rd(DMAPP_OFF_ENA_SET, 32'h100);
    // requests while masked must not start anything
    put(8'h08);
    repeat (20) @(posedge clk);
    chk("masked", 32'(rounds), 32'h0);
    wr(DMAPP_OFF_MASK_CLR, 32'h100);
    // buffer a by eight-byte bursts
    for (int i = 0; i < 8; i++) begin
      if (i > 0) put(8'h08);
      wait_round();
      // the write-back lands at the edge that closes the round
      @(negedge clk);
      w = partner_u.peek(BASE + 32'h88);
      if (i == 0) chk("count", {22'h0, w[13:4]}, 32'd55);
    end
    chk("rounds_a", 32'(rounds), 32'd8);
    chk("dones_a", 32'(dones), 32'd1);
    w = partner_u.peek(BASE + 32'h88);
    chk("mode_a", {29'h0, w[2:0]}, 32'h0);
    rd(DMAPP_OFF_STATUS, 32'h2);
    for (int i = 0; i < 64; i++)
      chk("buf_a", partner_u.peek(BUF_A + i), 32'(i));
    partner_u.mem[BASE + 32'h88] = PP_WORD;
    // single requests are ignored while burst-only is set
    wr(DMAPP_OFF_BURST_SET, 32'h100);
    put(8'h01);
    repeat (30) @(posedge clk);
    chk("burst_only", 32'(rounds), 32'd8);
    wr(DMAPP_OFF_BURST_CLR, 32'h100);
    // buffer b one single request at a time
    for (int i = 0; i < 64; i++) begin
      if (i > 0) put(8'h01);
      wait_round();
    end
    @(negedge clk);
    chk("rounds_b", 32'(rounds), 32'd72);
    chk("dones_b", 32'(dones), 32'd2);
    w = partner_u.peek(BASE + 32'h288);
    chk("mode_b", {29'h0, w[2:0]}, 32'h0);
    rd(DMAPP_OFF_STATUS, 32'h0);
    for (int i = 0; i < 64; i++)
      chk("buf_b", partner_u.peek(BUF_B + i), 32'(64 + i));
    // a control word left stopped halts the channel before any item moves
    partner_u.mem[BASE + 32'h88] = PP_WORD & 32'hffff_fff8;
    put(8'h01);
    repeat (20) @(posedge clk);
    chk("stopped", 32'(rounds), 32'd72);
    rd(DMAPP_OFF_ENA_SET, 32'h0);
    rd(DMAPP_OFF_STATUS, 32'h0);
    close_out();
  end
endmodule

/* tb/dmapp_periph_model.sv */
// dmapp_periph_model: receive peripheral with a fifo, plus system memory
// assumes one channel master; memory answers a read in the next cycle
`timescale 1ns/1ps
module dmapp_periph_model #(
  parameter logic [31:0] DATA_ADDR = 32'h4000_c000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fifo fill from the bench
  input wire logic fill_i,
  input wire logic [7:0] fill_n_i,
  // dma requests
  output logic req_single_o,
  output logic req_burst_o,
  // memory slave
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  output logic [31:0] mem_rdata_o
);
  logic [7:0] level_q;
  logic [7:0] serial_q;
  logic [31:0] mem [logic [31:0]];
  logic pop;

  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 32'hxxxx_xxxx;
  endfunction

  // a read of the data register pops one byte from the fifo
  assign pop = mem_rd_i && (mem_addr_i == DATA_ADDR);
  // burst from the trigger level of eight, single below it
  assign req_burst_o = (level_q >= 8'h08);
  assign req_single_o = (level_q != 8'h00) && !req_burst_o;

  // fifo level and the running byte pattern
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_q <= 8'h00;
      serial_q <= 8'h00;
    end else begin
      level_q <= level_q + (fill_i ? fill_n_i : 8'h00) - {7'h00, pop};
      serial_q <= serial_q + {7'h00, pop};
    end
  end

  // idle bus inverts its value every cycle, so the last word shows again on every second idle cycle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_rdata_o <= 32'h0000_0000;
    end else begin
      if (mem_wr_i) mem[mem_addr_i] = mem_wdata_i;
      if (pop) mem_rdata_o <= {24'h00_0000, serial_q};
      else if (mem_rd_i) mem_rdata_o <= peek(mem_addr_i);
      else mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule
